// ---- core/blt_ctrl.sv ----
// Purpose: black level threshold and offset correction control
// Assumes: classic Wishbone slave on ref_clk, averaging engine on same clock
// Notes:   registers reached over Wishbone, one word each
//          0x00 thresholds and their mode bits, 0x04 and 0x08 green offsets,
//          0x0c correction mode, 0x10 read-only working limits and enable
//          A write stores on the take edge, the same edge that raises ack
//          Unmapped words are acked, ignored on write and read as zero
//          Working limits and corrected offsets are registered outputs
//          The averaging engine shares ref_clk, so its inputs need no sync
// How it works
// R1: Lower threshold is six bits at 5:0, resets to four LSBs.
// R2: Override bit 7 freezes both thresholds at programmed values.
// R3: Upper threshold is seven bits at 14:8, defaults to lower plus five.
// R4: Override set makes internal black level maximum equal programmed upper.
// R5: Gain bit 15 without override reloads maximum after each averaging restart.
// R6: Gain bit 15 takes lower threshold straight from programmed field.
// R7: First green offset is sign-magnitude, bit 8 sign, 1 negative.
// R8: Second green offset uses the same sign-magnitude form.
// R9: Manual bit applies programmed offsets instead of automatic correction.
// R10: Mode 00 during ADC only, 10 continuous, X1 disables correction.
// R11: All fields reset to defaults; reserved bits read zero.
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "blt_consts.svh"
module blt_ctrl
	import blt_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`BLT_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Averaging engine
	input wire logic avgRestart,
	input wire logic avgValid,
	input wire logic [6:0] avgLevel,
	input wire logic adcActive,
	input wire blt_smag_t autoGreen1,
	input wire blt_smag_t autoGreen2,
	// Results
	output blt_limits_t activeLimits,
	output logic [9:0] firstGreenCorr,
	output logic [9:0] secondGreenCorr,
	output logic corrEnable
);

	// Register file and working state
	blt_thresh_t threshReg;
	blt_smag_t firstGreenOffsetReg;
	blt_smag_t secondGreenOffsetReg;
	blt_corr_t corrReg;
	logic [5:0] floorReg;
	logic [6:0] ceilReg;
	logic ackReg;
	logic [31:0] datReg;
	logic [9:0] g1Reg;
	logic [9:0] g2Reg;
	logic corrOnReg;

	// Bus and datapath nets
	logic busReq;
	logic wrEn;
	logic rdEn;
	logic [31:0] byteMask;
	logic [31:0] rdData;
	logic [15:0] threshNext;
	logic [15:0] g1Next;
	logic [15:0] g2Next;
	logic [15:0] corrNext;
	logic [1:0][9:0] offsetOut;
	logic corrOn;
	logic [6:0] floorExt;

	// One request per handshake; ack drops the cycle after it rose
	assign busReq = wb_cyc_i && wb_stb_i && !ackReg;
	assign wrEn = busReq && wb_we_i;
	assign rdEn = busReq && !wb_we_i;

	// Register word decode
	logic hitThresh;
	logic hitGreen1;
	logic hitGreen2;
	logic hitCorr;
	logic wrThresh;
	logic wrGreen1;
	logic wrGreen2;
	logic wrCorr;

	assign hitThresh = wb_adr_i == `BLT_OFS_THRESH;
	assign hitGreen1 = wb_adr_i == `BLT_OFS_GREEN1;
	assign hitGreen2 = wb_adr_i == `BLT_OFS_GREEN2;
	assign hitCorr = wb_adr_i == `BLT_OFS_CORR;
	// Writes store on the take edge, the same edge that raises ack
	assign wrThresh = wrEn && hitThresh;
	assign wrGreen1 = wrEn && hitGreen1;
	assign wrGreen2 = wrEn && hitGreen2;
	assign wrCorr = wrEn && hitCorr;

	always_comb begin
		byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
			{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	end

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] dat, input logic [31:0] m,
		input logic [15:0] keep);
		logic [15:0] res;
		res = (old & ~m[15:0]) | (dat[15:0] & m[15:0]);
		return res & keep; // R11
	endfunction

	assign threshNext = merge(threshReg, wb_dat_i, byteMask,
		`BLT_THRESH_MASK);
	assign g1Next = merge({7'h00, firstGreenOffsetReg}, wb_dat_i,
		byteMask, `BLT_SMAG_MASK);
	assign g2Next = merge({7'h00, secondGreenOffsetReg}, wb_dat_i,
		byteMask, `BLT_SMAG_MASK);
	assign corrNext = merge({13'h0000, corrReg}, wb_dat_i, byteMask,
		`BLT_CORR_MASK);

	// Threshold control register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			threshReg <= `BLT_THRESH_RST; // R1 R3 R11
		else if (wrThresh)
			threshReg <= threshNext;
	end

	// First green offset
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			firstGreenOffsetReg <= 9'h000; // R11
		else if (wrGreen1)
			firstGreenOffsetReg <= g1Next[8:0]; // R7
	end

	// Second green offset
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			secondGreenOffsetReg <= 9'h000; // R11
		else if (wrGreen2)
			secondGreenOffsetReg <= g2Next[8:0]; // R8
	end

	// Correction mode and manual override
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			corrReg <= 3'h0; // R9 R10 R11
		else if (wrCorr)
			corrReg <= corrNext[2:0];
	end

	assign floorExt = {1'b0, floorReg};

	// Which threshold source drives the working limits
	logic fixedBoth;
	logic fixedFloor;
	logic reloadCeil;

	assign fixedBoth = threshReg.override; // R2 R4
	assign fixedFloor = threshReg.override || threshReg.gainIndep; // R2 R6
	assign reloadCeil = avgRestart && threshReg.gainIndep; // R5

	// Tracking decisions for one averaged sample
	logic levelHigh;
	logic levelLow;
	logic floorCanRise;
	logic floorCanFall;
	logic ceilCanRise;
	logic ceilCanFall;
	logic [6:0] restartCeil;

	assign levelHigh = avgValid && avgLevel > ceilReg;
	assign levelLow = avgValid && avgLevel < floorExt;
	assign floorCanRise = floorReg != 6'h3f;
	assign floorCanFall = floorReg != 6'h00;
	assign ceilCanRise = ceilReg != 7'h7f;
	// Ceiling never tracks below the floor
	assign ceilCanFall = ceilReg > floorExt;
	// A restart rebuilds the ceiling from the reset floor, not the old one
	assign restartCeil = `BLT_FLOOR_RST + `BLT_CEIL_STEP; // R3

	// Working lower threshold; programmed sources win over tracking
	// so a mode change takes effect on the next edge
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			floorReg <= `BLT_FLOOR_RST; // R1
		else if (fixedFloor)
			floorReg <= threshReg.floorLim; // R2 R6
		else if (avgRestart)
			floorReg <= `BLT_FLOOR_RST; // R1
		else if (levelHigh && floorCanRise)
			floorReg <= floorReg + 6'h01;
		else if (levelLow && floorCanFall)
			floorReg <= floorReg - 6'h01;
	end

	// Working black level maximum; a reload on restart beats tracking
	// because the averaging engine starts over from the new bounds
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			ceilReg <= `BLT_FLOOR_RST + `BLT_CEIL_STEP; // R3
		else if (fixedBoth)
			ceilReg <= threshReg.ceiling; // R2 R4
		else if (reloadCeil)
			ceilReg <= threshReg.ceiling; // R5 R6
		else if (avgRestart)
			ceilReg <= restartCeil; // R3
		else if (levelHigh && ceilCanRise)
			ceilReg <= ceilReg + 7'h01;
		else if (levelLow && ceilCanFall)
			ceilReg <= ceilReg - 7'h01;
	end

	// Offset pairs, index 0 is the first green
	blt_smag_t [1:0] progPair;
	blt_smag_t [1:0] autoPair;

	assign progPair = {secondGreenOffsetReg, firstGreenOffsetReg};
	assign autoPair = {autoGreen2, autoGreen1};

	blt_offset_apply uApply (
		.corr(corrReg),
		.adcActive(adcActive),
		.progOffset(progPair),
		.autoOffset(autoPair),
		.offsetOut(offsetOut),
		.corrOn(corrOn)
	);

	// Registered offsets, zero while correction is off
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			g1Reg <= 10'h000;
			g2Reg <= 10'h000;
		end else begin
			g1Reg <= offsetOut[0]; // R7 R9
			g2Reg <= offsetOut[1]; // R8 R9
		end
	end

	// Registered correction enable, aligned with the offsets
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			corrOnReg <= 1'b0;
		else
			corrOnReg <= corrOn; // R10
	end

	// Read words, reserved and unused bits tied low
	logic [31:0] rdThresh;
	logic [31:0] rdGreen1;
	logic [31:0] rdGreen2;
	logic [31:0] rdCorr;
	logic [31:0] rdStatus;

	assign rdThresh = {16'h0000, threshReg}; // R11
	assign rdGreen1 = {23'h000000, firstGreenOffsetReg};
	assign rdGreen2 = {23'h000000, secondGreenOffsetReg};
	assign rdCorr = {29'h00000000, corrReg};
	assign rdStatus = {15'h0000, corrOnReg,
		1'b0, ceilReg, 2'b00, floorReg};

	// Read mux; unmapped words read zero
	always_comb begin
		unique case (wb_adr_i)
			`BLT_OFS_THRESH: rdData = rdThresh;
			`BLT_OFS_GREEN1: rdData = rdGreen1;
			`BLT_OFS_GREEN2: rdData = rdGreen2;
			`BLT_OFS_CORR: rdData = rdCorr;
			`BLT_OFS_STATUS: rdData = rdStatus;
			default: rdData = 32'h00000000; // R11
		endcase
	end

	// Ack answers every taken request one cycle later, mapped or not
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			ackReg <= 1'b0;
		else
			ackReg <= busReq;
	end

	// Read data is captured with the take and held until the next read
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			datReg <= 32'h00000000;
		else if (rdEn)
			datReg <= rdData;
	end

	assign wb_ack_o = ackReg;
	assign wb_dat_o = datReg;
	assign activeLimits = '{floorLim: floorReg, ceiling: ceilReg};
	assign firstGreenCorr = g1Reg;
	assign secondGreenCorr = g2Reg;
	assign corrEnable = corrOnReg;

endmodule
`default_nettype wire

// ---- core/blt_consts.svh ----
// Purpose: offsets, field positions and reset values of the black level
//          threshold control block
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes:   definitions only
`ifndef BLT_CONSTS_SVH
`define BLT_CONSTS_SVH

`define BLT_ADDR_W 5
`define BLT_OFS_THRESH 5'h00
`define BLT_OFS_GREEN1 5'h04
`define BLT_OFS_GREEN2 5'h08
`define BLT_OFS_CORR 5'h0c
`define BLT_OFS_STATUS 5'h10

`define BLT_FLOOR_LSB 0
`define BLT_FLOOR_MSB 5
`define BLT_OVR_BIT 7
`define BLT_CEIL_LSB 8
`define BLT_CEIL_MSB 14
`define BLT_GIND_BIT 15
`define BLT_SIGN_BIT 8

`define BLT_FLOOR_RST 6'h04
`define BLT_CEIL_STEP 7'h05
`define BLT_THRESH_RST 16'h0904
`define BLT_THRESH_MASK 16'hffbf
`define BLT_SMAG_MASK 16'h01ff
`define BLT_CORR_MASK 16'h0007
`define BLT_CORR_RST 16'h0000

`endif

// ---- core/blt_pkg.sv ----
// Purpose: types shared by the black level threshold control files
// Assumes: field layout from blt_consts.svh
// Notes:   structs map one to one onto register bits, except blt_limits_t, which orders the working limits differently
package blt_pkg;

	typedef struct packed {
		logic gainIndep;
		logic [6:0] ceiling;
		logic override;
		logic rsvd;
		logic [5:0] floorLim;
	} blt_thresh_t;

	typedef struct packed {
		logic sign;
		logic [7:0] mag;
	} blt_smag_t;

	typedef struct packed {
		logic [1:0] calMode;
		logic manual;
	} blt_corr_t;

	typedef struct packed {
		logic [5:0] floorLim;
		logic [6:0] ceiling;
	} blt_limits_t;

endpackage

// ---- core/blt_offset_apply.sv ----
// Purpose: picks and gates the analog offset correction for both greens
// Assumes: all inputs on ref_clk, combinational
// Notes:   output is two's complement, zero when correction is off
`timescale 1ns/1ps
`default_nettype none
module blt_offset_apply
	import blt_pkg::*;
(
	// Configuration
	input wire blt_corr_t corr,
	input wire logic adcActive,
	// Programmed and automatic values, index 0 = first green
	input wire blt_smag_t [1:0] progOffset,
	input wire blt_smag_t [1:0] autoOffset,
	// Result
	output logic [1:0][9:0] offsetOut,
	output logic corrOn
);

	always_comb begin
		if (corr.calMode[0])
			corrOn = 1'b0; // R10
		else if (corr.calMode[1])
			corrOn = 1'b1; // R10
		else
			corrOn = adcActive; // R10
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gChan
			blt_smag_t sel;
			logic [9:0] mag10;
			assign sel = corr.manual ? progOffset[g] : autoOffset[g]; // R9
			assign mag10 = {2'b00, sel.mag};
			// Sign bit set means negative; R7 R8
			assign offsetOut[g] = !corrOn ? 10'h000 :
				(sel.sign ? (~mag10 + 10'h001) : mag10);
		end
	endgenerate

endmodule
`default_nettype wire

// ---- verif/blt_ctrl_properties.sv ----
// Purpose: bus and correction checks on the blt_ctrl ports
// Assumes: bound to every blt_ctrl instance
// Notes: keeps a shadow of the correction word
`timescale 1ns/1ps
`default_nettype none
`include "blt_consts.svh"
module blt_ctrl_props
	import blt_pkg::*;
(
	// Clock, reset and bus
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`BLT_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Correction
	input wire logic adcActive,
	input wire blt_smag_t autoGreen1,
	input wire blt_smag_t autoGreen2,
	input wire logic [9:0] firstGreenCorr,
	input wire logic [9:0] secondGreenCorr,
	input wire logic corrEnable
);
	logic [2:0] corr_reg;
	logic take;
	logic rd;
	logic en;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd = wb_ack_o && !wb_we_i;
	assign en = !corr_reg[1] && (corr_reg[2] || adcActive);
	function automatic logic [9:0] sm(blt_smag_t v);
		return v.sign ? 10'h0 - {2'h0, v.mag} : {2'h0, v.mag};
	endfunction
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			corr_reg <= 3'h0;
		else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == `BLT_OFS_CORR)
			corr_reg <= wb_dat_i[2:0];
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	property p_ack; take |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_unm; rd && wb_adr_i > 5'h10 |-> wb_dat_o == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	property p_thr; rd && wb_adr_i == 5'h00 |-> !wb_dat_o[6]; endproperty
	a_thr: assert property (p_thr) else $error("thresh rsvd");
	property p_grn; rd && wb_adr_i inside {5'h04, 5'h08} |->
		wb_dat_o[31:9] == 23'h0; endproperty
	a_grn: assert property (p_grn) else $error("green width");
	property p_cor; rd && wb_adr_i == 5'h0c |-> wb_dat_o[31:3] == 29'h0;
		endproperty
	a_cor: assert property (p_cor) else $error("corr width");
	property p_en; 1 |=> corrEnable == $past(en); endproperty
	a_en: assert property (p_en) else $error("corr enable");
	property p_off; !corrEnable |-> firstGreenCorr == 10'h0 &&
		secondGreenCorr == 10'h0; endproperty
	a_off: assert property (p_off) else $error("corr not off");
	property p_auto; !corr_reg[0] |=> firstGreenCorr ==
		$past(en ? sm(autoGreen1) : 10'h0); endproperty
	a_auto: assert property (p_auto) else $error("auto green");
endmodule
bind blt_ctrl blt_ctrl_props chk (.*);
`default_nettype wire

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench for blt_ctrl
// Assumes: classic Wishbone, ack one cycle after take
// Notes: seeded random fields with fixed corners
`timescale 1ns/1ps
`default_nettype none
`include "blt_consts.svh"
module tb_top
	import blt_pkg::*;
;
	logic ref_clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [4:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, q;
	logic wb_ack_o, avgRestart = 0, avgValid = 0, adcActive = 0, corrEnable;
	logic [6:0] avgLevel = 0;
	blt_smag_t autoGreen1 = 0, autoGreen2 = 0, g1, g2;
	blt_limits_t activeLimits;
	logic [9:0] firstGreenCorr, secondGreenCorr;
	logic [5:0] f;
	logic [6:0] c;
	logic en;
	int fails = 0, checked = 0, cycles = 0;
	blt_ctrl dut (.*);
	initial forever #12.5 ref_clk = ~ref_clk;
	function automatic logic [9:0] sm(blt_smag_t v);
		return v.sign ? 10'h0 - {2'h0, v.mag} : {2'h0, v.mag};
	endfunction
	task end_sim;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge ref_clk);
	endtask
	task avg(input logic r, input logic v, input logic [6:0] l);
		avgRestart <= r;
		avgValid <= v;
		avgLevel <= l;
		@(posedge ref_clk);
		avgRestart <= 0;
		avgValid <= 0;
		@(posedge ref_clk);
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		void'($urandom(13130));
		repeat (16) @(posedge ref_clk);
		sys_rst <= 0;
		wb(0, `BLT_OFS_THRESH, 0);
		chk("thr rst", q, 32'h0904);
		wb(0, `BLT_OFS_STATUS, 0);
		chk("stat rst", q, 32'h0904);
		chk("lim rst", 32'(activeLimits), 32'h0209);
		for (int a = 4; a <= 12; a += 4) begin
			wb(0, a[4:0], 0);
			chk("reg rst", q, 0);
		end
		for (int i = 0; i < 4; i++) begin
			f = (i == 0) ? 6'h3f : 6'($urandom);
			c = (i == 0) ? 7'h00 : 7'($urandom);
			wb(1, `BLT_OFS_THRESH, {16'h0, 1'b0, c, 2'b11, f});
			wb(0, `BLT_OFS_THRESH, 0);
			chk("thr rd", q, {16'h0, 1'b0, c, 2'b10, f});
			avg(1, 1, 7'($urandom));
			chk("ovr", 32'(activeLimits), 32'({f, c}));
			f = ~f;
			c = ~c;
			wb(1, `BLT_OFS_THRESH, {16'h0, 1'b1, c, 2'b00, f});
			chk("gi flr", 32'(activeLimits.floorLim), 32'(f));
			avg(1, 0, 0);
			chk("gi ceil", 32'(activeLimits.ceiling), 32'(c));
			wb(1, `BLT_OFS_THRESH, 0);
			avg(1, 0, 0);
			chk("auto", 32'(activeLimits), 32'h0209);
			avg(0, 1, 7'h7f);
			chk("auto up", 32'(activeLimits), 32'h028a);
			avg(0, 1, 7'h00);
			chk("auto dn", 32'(activeLimits), 32'h0209);
		end
		g1 = 9'h1ff;
		g2 = 9'($urandom);
		wb(1, `BLT_OFS_GREEN1, {23'($urandom), g1});
		wb(0, `BLT_OFS_GREEN1, 0);
		chk("g1 rd", q, 32'(g1));
		wb(1, `BLT_OFS_GREEN2, {23'($urandom), g2});
		wb(0, `BLT_OFS_GREEN2, 0);
		chk("g2 rd", q, 32'(g2));
		for (int m = 0; m < 16; m++) begin
			wb(1, `BLT_OFS_CORR, 32'(m[2:0]));
			adcActive <= m[3];
			autoGreen1 <= 9'($urandom);
			autoGreen2 <= 9'($urandom);
			repeat (2) @(posedge ref_clk);
			en = !m[1] && (m[2] || m[3]);
			chk("en", 32'(corrEnable), 32'(en));
			chk("c1", 32'(firstGreenCorr),
				en ? 32'(sm(m[0] ? g1 : autoGreen1)) : 0);
			chk("c2", 32'(secondGreenCorr),
				en ? 32'(sm(m[0] ? g2 : autoGreen2)) : 0);
		end
		wb(0, 5'h14, 0);
		chk("unmapped", q, 0);
		end_sim();
	end
endmodule
`default_nettype wire
